// File: src/pssd_pkg.sv
// Purpose: constants for the soft-strap default block
// Assumes: 25 MHz clock, 32-bit APB
// Notes: offsets are byte addresses
package pssd_pkg;
    // register byte offsets
    localparam logic [7:0] STRAP_LATCHED = 8'h00;
    localparam logic [7:0] STRAP_OVERRIDE = 8'h04;
    localparam logic [7:0] STRAP_EFFECTIVE = 8'h08;
    localparam logic [7:0] CONTROL = 8'h0c;
    localparam logic [7:0] PORT1_FLOW = 8'h10;
    localparam logic [7:0] PORT1_BASIC = 8'h14;
    localparam logic [7:0] PORT1_ADV = 8'h18;
    localparam logic [7:0] PORT1_MODES = 8'h1c;
    localparam logic [7:0] PORT2_BASIC = 8'h20;
    localparam logic [7:0] PORT2_ADV = 8'h24;
    localparam logic [7:0] PORT2_MODES = 8'h28;
    localparam logic [7:0] HW_CONFIG = 8'h2c;
    localparam logic [7:0] PORT2_XOVER = 8'h30;
    // strap vector bit positions
    localparam int S_P1_RATE = 0;
    localparam int S_P1_DUPLEX = 1;
    localparam int S_P1_BP = 2;
    localparam int S_P1_PAUSE = 3;
    localparam int S_P1_FORCED = 4;
    localparam int S_P2_AUTOX = 5;
    localparam int S_P2_MANX = 6;
    localparam int S_P2_AN = 7;
    localparam int S_P2_RATE = 8;
    localparam int STRAP_W = 9;
    // tie-off defaults; bit 5 comes from its pin
    localparam logic [8:0] STRAP_TIEOFF = 9'h18f;
    // target register field positions
    localparam int F_BP = 0;
    localparam int F_TXP = 1;
    localparam int F_RXP = 2;
    localparam int F_MANFC = 3;
    localparam int F_DUPLEX = 8;
    localparam int F_AN = 12;
    localparam int F_RATE = 13;
    localparam int F_ADV10H = 5;
    localparam int F_ADV10F = 6;
    localparam int F_SYMP = 10;
    localparam int F_ASYMP = 11;
    localparam int F_AUTOX = 0;
    localparam int F_XSEL = 0;
    localparam int F_XOUT = 1;
    // control register bits (self-clearing commands)
    localparam int C_DIG_RST = 0;
    localparam int C_RELOAD = 1;
endpackage

// File: src/pssd_defaults.sv
// Purpose: derive register reset defaults for one port from its straps
// Assumes: straps already latched
// Notes: instantiated once per PHY port
`timescale 1ns/100ps
module pssd_defaults (
    input wire logic rate,
    input wire logic duplex,
    input wire logic autoneg,
    input wire logic pause,
    input wire logic forced,
    output logic [15:0] basic_default,
    output logic [15:0] adv_default,
    output logic [2:0] mode_default
);
    always_comb begin
        basic_default = 16'h0000;
        basic_default[pssd_pkg::F_RATE] = rate;
        basic_default[pssd_pkg::F_DUPLEX] = duplex;
        basic_default[pssd_pkg::F_AN] = autoneg;
        adv_default = 16'h0000;
        // 10 Mb half ability always set; full ability set by duplex or rate
        adv_default[pssd_pkg::F_ADV10H] = 1'b1;
        adv_default[pssd_pkg::F_ADV10F] = duplex | rate;
        // pause advertisement from manual and full-duplex flow control
        adv_default[pssd_pkg::F_SYMP] = forced ? pause : 1'b1;
        adv_default[pssd_pkg::F_ASYMP] = forced ? 1'b0 : pause;
        mode_default = {autoneg, rate, duplex};
    end
endmodule // pssd_defaults

// File: src/pssd_top.sv
// Purpose: soft-strap latch and default loader for PHY ports 1 and 2
// Assumes: APB register access, synchronous reset
// Notes: straps feed target registers on each reset of those registers
// Operation
// R01 - port 1 rate strap defaults to 1 and sets speed LSB, mode field and 10 Mb abilities; here it sets only 10 Mb full, 10 Mb half is always set.
// R02 - port 1 duplex strap defaults to 1 and sets duplex bit, mode field and 10 Mb full ability.
// R03 - port 1 backpressure strap defaults to 1 and loads the backpressure enable bit.
// R04 - port 1 pause strap defaults to 1 and loads both pause enables, shaping asymmetric pause.
// R05 - port 1 manual flow strap defaults to 0, loads the manual select and shapes pause ads.
// R06 - port 2 auto crossover strap comes from its pin into the hardware config register.
// R07 - with auto crossover low and strap use selected, manual strap 0 is straight, 1 crossed.
// R08 - port 2 negotiation strap defaults to 1 and loads the negotiation enable bit.
// R09 - port 2 rate strap defaults to 1 and sets speed LSB, 10 Mb abilities and mode field; port 2 duplex is tied to 1, so both 10 Mb abilities stay set.
// R10 - straps are captured on power-on or pin reset and replaced by eeprom loader values.
// R11 - digital reset or reload without eeprom restores latched values without resampling.
// R12 - strap defaults load whenever target registers reset; writes hold until the next one.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module pssd_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic auto_crossover_pin,
    input wire logic eeprom_valid,
    input wire logic eeprom_load,
    input wire logic [8:0] eeprom_straps,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic port2_crossed
);
    localparam int W = pssd_pkg::STRAP_W;

    logic [W-1:0] latched, next_latched;
    logic [W-1:0] eff, next_eff;
    logic [15:0] p1_flow, next_p1_flow;
    logic [15:0] p1_basic, next_p1_basic;
    logic [15:0] p1_adv, next_p1_adv;
    logic [2:0] p1_mode, next_p1_mode;
    logic [15:0] p2_basic, next_p2_basic;
    logic [15:0] p2_adv, next_p2_adv;
    logic [2:0] p2_mode, next_p2_mode;
    logic [1:0] xover, next_xover;
    logic pin_rst_d, next_pin_rst_d;
    logic [15:0] d1_basic, d1_adv, d2_basic, d2_adv;
    logic [2:0] d1_mode, d2_mode;
    logic wr, rd, soft_rst, reload, reg_reset;

    // defaults follow next_eff so a reload applies the new straps on the same edge
    pssd_defaults u_port1 (
        .rate(next_eff[pssd_pkg::S_P1_RATE]), // see R01
        .duplex(next_eff[pssd_pkg::S_P1_DUPLEX]), // see R02
        .autoneg(1'b1),
        .pause(next_eff[pssd_pkg::S_P1_PAUSE]), // see R04
        .forced(next_eff[pssd_pkg::S_P1_FORCED]), // see R05
        .basic_default(d1_basic),
        .adv_default(d1_adv),
        .mode_default(d1_mode)
    );

    // port 2 duplex and flow straps are outside this block, tied to their defaults
    pssd_defaults u_port2 (
        .rate(next_eff[pssd_pkg::S_P2_RATE]), // see R09
        .duplex(1'b1),
        .autoneg(next_eff[pssd_pkg::S_P2_AN]), // see R08
        .pause(1'b1),
        .forced(1'b0),
        .basic_default(d2_basic),
        .adv_default(d2_adv),
        .mode_default(d2_mode)
    );

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    // control bits act only in the write access cycle and read back as zero
    assign soft_rst = wr & (paddr == pssd_pkg::CONTROL) & pwdata[pssd_pkg::C_DIG_RST];
    assign reload = wr & (paddr == pssd_pkg::CONTROL) & pwdata[pssd_pkg::C_RELOAD];
    // every register answers at once, so no wait states
    assign pready = 1'b1;

    // pin capture happens one cycle after reset release
    always_comb begin
        next_pin_rst_d = 1'b0;
        next_latched = latched;
        if (pin_rst_d) begin
            next_latched = pssd_pkg::STRAP_TIEOFF;
            next_latched[pssd_pkg::S_P2_AUTOX] = auto_crossover_pin; // see R06, R10
        end
    end

    // an eeprom load wins over a digital reset or reload in the same cycle
    always_comb begin
        next_eff = eff;
        reg_reset = pin_rst_d | soft_rst | reload;
        if (pin_rst_d) begin
            next_eff = next_latched; // see R10
        end else if ((soft_rst | reload) && !eeprom_valid) begin
            next_eff = latched; // see R11
        end
        if (eeprom_load && eeprom_valid) begin
            next_eff = eeprom_straps; // see R10
            reg_reset = 1'b1;
        end
    end

    // target registers: loaded from strap defaults on reset, else software
    always_comb begin
        next_p1_flow = p1_flow;
        next_p1_basic = p1_basic;
        next_p1_adv = p1_adv;
        next_p1_mode = p1_mode;
        next_p2_basic = p2_basic;
        next_p2_adv = p2_adv;
        next_p2_mode = p2_mode;
        next_xover = xover;
        if (reg_reset) begin
            next_p1_flow = 16'h0000;
            next_p1_flow[pssd_pkg::F_BP] = next_eff[pssd_pkg::S_P1_BP]; // see R03
            next_p1_flow[pssd_pkg::F_TXP] = next_eff[pssd_pkg::S_P1_PAUSE]; // see R04
            next_p1_flow[pssd_pkg::F_RXP] = next_eff[pssd_pkg::S_P1_PAUSE]; // see R04
            next_p1_flow[pssd_pkg::F_MANFC] = next_eff[pssd_pkg::S_P1_FORCED]; // see R05
            next_p1_basic = d1_basic; // see R12
            next_p1_adv = d1_adv;
            next_p1_mode = d1_mode;
            next_p2_basic = d2_basic;
            next_p2_adv = d2_adv;
            next_p2_mode = d2_mode;
            next_xover = 2'h0;
        end else if (wr) begin
            // writes to read-only or unmapped offsets are dropped
            case (paddr)
                pssd_pkg::PORT1_FLOW: next_p1_flow = pwdata[15:0]; // see R12
                pssd_pkg::PORT1_BASIC: next_p1_basic = pwdata[15:0];
                pssd_pkg::PORT1_ADV: next_p1_adv = pwdata[15:0];
                pssd_pkg::PORT1_MODES: next_p1_mode = pwdata[2:0];
                pssd_pkg::PORT2_BASIC: next_p2_basic = pwdata[15:0];
                pssd_pkg::PORT2_ADV: next_p2_adv = pwdata[15:0];
                pssd_pkg::PORT2_MODES: next_p2_mode = pwdata[2:0];
                pssd_pkg::PORT2_XOVER: next_xover[pssd_pkg::F_XSEL] = pwdata[0];
                default: next_xover = xover;
            endcase
        end

        // crossover choice: strap use selected and auto strap low
        if (next_xover[pssd_pkg::F_XSEL] && !eff[pssd_pkg::S_P2_AUTOX]) begin
            next_xover[pssd_pkg::F_XOUT] = eff[pssd_pkg::S_P2_MANX]; // see R07
        end else begin
            next_xover[pssd_pkg::F_XOUT] = 1'b0;
        end
    end

    // reset values only hold until the pin capture cycle after release
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_rst_d <= 1'b1;
            latched <= pssd_pkg::STRAP_TIEOFF;
            eff <= pssd_pkg::STRAP_TIEOFF;
            p1_flow <= 16'h0000;
            p1_basic <= 16'h0000;
            p1_adv <= 16'h0000;
            p1_mode <= 3'h0;
            p2_basic <= 16'h0000;
            p2_adv <= 16'h0000;
            p2_mode <= 3'h0;
            xover <= 2'h0;
        end else begin
            pin_rst_d <= next_pin_rst_d;
            latched <= next_latched;
            eff <= next_eff;
            p1_flow <= next_p1_flow;
            p1_basic <= next_p1_basic;
            p1_adv <= next_p1_adv;
            p1_mode <= next_p1_mode;
            p2_basic <= next_p2_basic;
            p2_adv <= next_p2_adv;
            p2_mode <= next_p2_mode;
            xover <= next_xover;
        end
    end

    // registered, so the pin never glitches while software writes the select
    assign port2_crossed = xover[pssd_pkg::F_XOUT];

    // read data and error taken in the setup cycle and registered,
    // so both stand through the access cycle with no wait state
    logic [31:0] rdata, next_prdata;
    logic next_err;
    always_comb begin
        rdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            pssd_pkg::STRAP_LATCHED: rdata = {23'h000000, latched};
            pssd_pkg::STRAP_EFFECTIVE: rdata = {23'h000000, eff};
            pssd_pkg::STRAP_OVERRIDE: rdata = {31'h00000000, eeprom_valid};
            pssd_pkg::CONTROL: rdata = 32'h00000000;
            pssd_pkg::PORT1_FLOW: rdata = {16'h0000, p1_flow};
            pssd_pkg::PORT1_BASIC: rdata = {16'h0000, p1_basic};
            pssd_pkg::PORT1_ADV: rdata = {16'h0000, p1_adv};
            pssd_pkg::PORT1_MODES: rdata = {29'h00000000, p1_mode};
            pssd_pkg::PORT2_BASIC: rdata = {16'h0000, p2_basic};
            pssd_pkg::PORT2_ADV: rdata = {16'h0000, p2_adv};
            pssd_pkg::PORT2_MODES: rdata = {29'h00000000, p2_mode};
            pssd_pkg::HW_CONFIG: rdata = {31'h00000000, eff[pssd_pkg::S_P2_AUTOX]}; // see R06
            pssd_pkg::PORT2_XOVER: rdata = {30'h00000000, xover};
            default: next_err = psel & ~penable;
        endcase
        next_prdata = rd ? rdata : 32'h00000000;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_err;
        end
    end
endmodule // pssd_top

// File: tb/pssd_checker.sv
// Purpose: port checks for the soft-strap block
// Assumes: zero wait APB, one clock
// Notes: bound to pssd_top
`timescale 1ns/100ps
module pssd_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic auto_crossover_pin,
    input wire logic eeprom_valid,
    input wire logic eeprom_load,
    input wire logic [8:0] eeprom_straps,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic port2_crossed
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic acc;
    logic bad;
    logic wr;
    assign acc = psel && penable;
    assign bad = (paddr > pssd_pkg::PORT2_XOVER) || (paddr[1:0] != 2'h0);
    assign wr = acc && pwrite;
    chk_ready_high: assert property (acc |-> pready)
        else $error("ready low in access");
    chk_unmapped_err: assert property (acc && bad |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && !bad |-> !pslverr)
        else $error("mapped access refused");
    chk_idle_data: assert property (!acc |-> prdata == 32'h0)
        else $error("read data outside access");
    chk_ctrl_zero: assert property (acc && !pwrite && paddr == pssd_pkg::CONTROL |-> prdata == 32'h0)
        else $error("command register reads nonzero");
    chk_latch_ties: assert property (acc && !pwrite && paddr == pssd_pkg::STRAP_LATCHED |->
        prdata[31:9] == 23'h000000 && prdata[4:0] == pssd_pkg::STRAP_TIEOFF[4:0] &&
        prdata[8:6] == pssd_pkg::STRAP_TIEOFF[8:6])
        else $error("latched straps differ from tie-offs");
    chk_cross_cause: assert property ($changed(port2_crossed) |->
        $past(wr) || $past(wr, 2) || $past(eeprom_load) || $past(eeprom_load, 2))
        else $error("crossover changed without cause");
    chk_cross_reset: assert property ($fell(sys_rst) |-> !port2_crossed)
        else $error("crossover set out of reset");
    chk_load_ignored: assert property (eeprom_load && !eeprom_valid && !acc |=> $stable(port2_crossed))
        else $error("load taken without valid eeprom");
endmodule // pssd_checker

bind pssd_top pssd_checker pssd_checker_i (.clock(clock), .sys_rst(sys_rst),
    .auto_crossover_pin(auto_crossover_pin), .eeprom_valid(eeprom_valid),
    .eeprom_load(eeprom_load), .eeprom_straps(eeprom_straps), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port2_crossed(port2_crossed));

// File: tb/pssd_top_tb.sv
// Purpose: self-checking bench for the soft-strap block
// Assumes: zero wait APB, 25 MHz clock
// Notes: expectations follow the strap bit order
`timescale 1ns/100ps
module pssd_top_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic pin = 1'b1;
    logic ev = 1'b0;
    logic el = 1'b0;
    logic [8:0] es = 9'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crossed;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int samples_checked = 0;
    pssd_top pssd_top_i (.clock(clock), .sys_rst(sys_rst), .auto_crossover_pin(pin),
        .eeprom_valid(ev), .eeprom_load(el), .eeprom_straps(es), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port2_crossed(crossed));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic stop_test();
        $display("mismatches %0d of %0d checks", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic load(input logic v, input logic [8:0] s);
        @(posedge clock);
        ev <= v;
        el <= 1'b1;
        es <= s;
        @(posedge clock);
        el <= 1'b0;
    endtask
    task automatic t_defaults();
        apb(1'b0, pssd_pkg::STRAP_LATCHED, 32'h0);
        chk(rd, 32'h1af);
        apb(1'b0, pssd_pkg::HW_CONFIG, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b0, pssd_pkg::PORT1_FLOW, 32'h0);
        chk(rd[3:0], 4'h7);
        apb(1'b0, pssd_pkg::PORT2_BASIC, 32'h0);
        chk(rd[12], 1'b1);
        apb(1'b0, pssd_pkg::PORT1_BASIC, 32'h0);
        chk(rd, 32'h00003100);
        apb(1'b0, pssd_pkg::PORT1_MODES, 32'h0);
        chk(rd, 32'h00000007);
        apb(1'b0, pssd_pkg::PORT1_ADV, 32'h0);
        chk(rd, 32'h00000c60);
        apb(1'b0, pssd_pkg::PORT2_MODES, 32'h0);
        chk(rd, 32'h00000007);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h00000000, er}, 32'h00000001);
        chk(rd, 32'h00000000);
    endtask
    task automatic t_override();
        pin <= 1'b0;
        apb(1'b1, pssd_pkg::PORT1_FLOW, 32'h0);
        apb(1'b0, pssd_pkg::PORT1_FLOW, 32'h0);
        chk(rd[3:0], 4'h0);
        apb(1'b1, pssd_pkg::CONTROL, 32'h1);
        apb(1'b0, pssd_pkg::STRAP_LATCHED, 32'h0);
        chk(rd, 32'h1af);
        apb(1'b0, pssd_pkg::PORT1_FLOW, 32'h0);
        chk(rd[3:0], 4'h7);
        load(1'b1, 9'h040);
        apb(1'b0, pssd_pkg::STRAP_EFFECTIVE, 32'h0);
        chk(rd, 32'h040);
        apb(1'b0, pssd_pkg::PORT1_FLOW, 32'h0);
        chk(rd[3:0], 4'h0);
        apb(1'b0, pssd_pkg::PORT2_BASIC, 32'h0);
        chk(rd, 32'h00000100);
        apb(1'b0, pssd_pkg::PORT1_BASIC, 32'h0);
        chk(rd, 32'h00001000);
        apb(1'b1, pssd_pkg::PORT2_XOVER, 32'h1);
        apb(1'b0, pssd_pkg::PORT2_XOVER, 32'h0);
        chk({crossed, rd[1:0]}, 3'h7);
        load(1'b1, 9'h000);
        apb(1'b1, pssd_pkg::PORT2_XOVER, 32'h1);
        apb(1'b0, pssd_pkg::PORT2_XOVER, 32'h0);
        chk({crossed, rd[1:0]}, 3'h1);
    endtask
    task automatic t_revert();
        load(1'b0, 9'h040);
        apb(1'b1, pssd_pkg::CONTROL, 32'h2);
        apb(1'b0, pssd_pkg::STRAP_EFFECTIVE, 32'h0);
        chk(rd, 32'h1af);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        apb(1'b0, pssd_pkg::STRAP_LATCHED, 32'h0);
        chk(rd, 32'h18f);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        t_defaults();
        t_override();
        t_revert();
        stop_test();
    end
endmodule // pssd_top_tb
